// ===== esc_params.svh
// Constants for the electronic load setpoint and transient controller
`ifndef ESC_PARAMS_SVH
`define ESC_PARAMS_SVH
// Setpoint units: resistance in 10 milliohm steps, power in 10 milliwatt steps
`define ESC_RES_LOW_MIN    32'h0000_0001
`define ESC_RES_LOW_MAX    32'h016e_3600
`define ESC_RES_HIGH_MIN   32'h0000_0014
`define ESC_RES_HIGH_MAX   32'h0e4e_1c00
`define ESC_POW_MIN        32'h0000_0000
`define ESC_POW_MAX        32'h0003_0d40
// Transient timing
`define ESC_TICK_NS        10000
`define ESC_CLK_NS         25
`define ESC_TICK_CYC       (`ESC_TICK_NS / `ESC_CLK_NS)
`define ESC_TIME_MIN       32'h0000_0001
`define ESC_TIME_MAX       32'h000f_4240
// Two dwells plus two edges must not run faster than 50 kHz, i.e. two ticks
`define ESC_PERIOD_MIN     32'h0000_0002
`endif

// ===== esc_pkg.sv
// Types shared by the setpoint and transient controller
package esc_pkg;
  typedef enum logic [3:0] {
    ESC_CUR_LOW, ESC_CUR_HIGH, ESC_VOLT_LOW, ESC_VOLT_HIGH,
    resistance_low_range_e, resistance_high_range_e, constant_power_mode_e,
    current_with_voltage_limit_e, resistance_with_voltage_limit_e,
    power_with_voltage_limit_e
  } esc_mode_t;
  typedef enum logic [1:0] {ESC_CONT, ESC_PULSE, ESC_TOGGLE} esc_style_t;
  typedef enum logic [2:0] {ESC_LOW, ESC_RISE, ESC_HIGH, ESC_FALL} esc_phase_t;
endpackage

// ===== esc_clamp.sv
// Saturating clamp of a setpoint into a range
`timescale 1ns/10ps
module esc_clamp #(
  parameter int W = 32
) (
  // Value and bounds
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lo,
  input  wire logic [W-1:0] hi,
  // Result
  output logic      [W-1:0] result
);
  // Crossed bounds: values below lo take lo, all others take hi
  always_comb begin
    if (value < lo) begin
      result = lo;
    end else if (value > hi) begin
      result = hi;
    end else begin
      result = value;
    end
  end
endmodule

// ===== esc_ctrl.sv
// Setpoint, trigger and transient sequencing for the electronic load
// Overview of operation
// - Mode or range change disables enabled input
// - Resistance bounded per low/high range
// - Range switch forces resistance to new minimum
// - Trigger copies triggered resistance to immediate
// - Resistance mode with input on: apply now
// - Otherwise triggered resistance waits for resistance mode
// - Consumed trigger preset needs a fresh preset write
// - Trigger loads triggered power, applied in power mode
// - Current plus voltage limit: limit above threshold
// - Resistance plus voltage limit: clamp above threshold
// - Power plus voltage limit: clamp above threshold
// - Transient alternates high/low; three styles
// - Transient levels share basic mode ranges
// - Dwell and edge times 10us to 10s
// - Transient enabled by key or command
// - Turn-on or current shutdown stops transient
// - Resistance transient uses immediate as other level
// - Out of range writes clamp to bounds
`timescale 1ns/10ps
`include "esc_params.svh"
module esc_ctrl #(
  parameter int W        = 32,
  parameter int TICK_CYC = `ESC_TICK_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Mode and input control from the command decoder
  input  wire esc_pkg::esc_mode_t mode_sel,
  input  wire logic              mode_wr,
  input  wire logic              input_on_req,
  input  wire logic              input_off_req,
  // Setpoint writes, one strobe per value
  input  wire logic [W-1:0]      wr_data,
  input  wire logic              res_wr,
  input  wire logic              res_trig_wr,
  input  wire logic              pow_wr,
  input  wire logic              pow_trig_wr,
  input  wire logic              transient_high_level_wr,
  // Transient timing writes, in 10us ticks
  input  wire logic              high_dwell_time_wr,
  input  wire logic              low_dwell_time_wr,
  input  wire logic              rise_edge_time_wr,
  input  wire logic              fall_edge_time_wr,
  input  wire esc_pkg::esc_style_t style_sel,
  // Transient on/off from key and command
  input  wire logic              transient_key,
  input  wire logic              transient_cmd_on,
  input  wire logic              transient_cmd_off,
  // Trigger sources
  input  wire logic              ext_trigger_pin,
  input  wire logic              cmd_trigger,
  // Protection and measurement (from the analog side)
  input  wire logic              von_shutdown_pin,
  input  wire logic              current_prot_pin,
  input  wire logic              over_voltage_limit_pin,
  // Outputs
  output logic                   input_enabled,
  output logic                   transient_active,
  output logic                   transient_at_high,
  output logic                   transient_in_edge,
  output logic [W-1:0]           res_setpoint,
  output logic [W-1:0]           pow_setpoint,
  output logic [W-1:0]           applied_setpoint,
  output logic                   voltage_limit_active,
  output logic                   trigger_pending
);
  // Synchronisers for pin inputs
  logic [1:0] sync_ext, sync_von, sync_prot, sync_ovl;
  logic       ext_prev;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_ext  <= 2'h0;
      sync_von  <= 2'h0;
      sync_prot <= 2'h0;
      sync_ovl  <= 2'h0;
      ext_prev  <= 1'h0;
    end else begin
      sync_ext  <= {sync_ext[0], ext_trigger_pin};
      sync_von  <= {sync_von[0], von_shutdown_pin};
      sync_prot <= {sync_prot[0], current_prot_pin};
      sync_ovl  <= {sync_ovl[0], over_voltage_limit_pin};
      ext_prev  <= sync_ext[1];
    end
  end

  logic trig_evt;
  logic shutdown;
  assign trig_evt = cmd_trigger | (sync_ext[1] & ~ext_prev);
  assign shutdown = sync_von[1] | sync_prot[1];

  // Current mode and range bounds
  esc_pkg::esc_mode_t mode;
  logic res_mode, pow_mode, high_range;
  assign high_range = (mode == esc_pkg::resistance_high_range_e);
  assign res_mode = (mode == esc_pkg::resistance_low_range_e) | high_range |
                    (mode == esc_pkg::resistance_with_voltage_limit_e);
  assign pow_mode = (mode == esc_pkg::constant_power_mode_e) |
                    (mode == esc_pkg::power_with_voltage_limit_e);
  logic [W-1:0] res_lo, res_hi;
  assign res_lo = high_range ? `ESC_RES_HIGH_MIN : `ESC_RES_LOW_MIN;
  assign res_hi = high_range ? `ESC_RES_HIGH_MAX : `ESC_RES_LOW_MAX;

  // Shared clamp for incoming values; kept single since one strobe a cycle
  logic [W-1:0] lo_sel, hi_sel, wr_clamped;
  logic         is_res_wr;
  assign is_res_wr = res_wr | res_trig_wr | (transient_high_level_wr & res_mode);
  always_comb begin
    if (is_res_wr) begin
      lo_sel = res_lo;
      hi_sel = res_hi;
    end else if (pow_wr | pow_trig_wr | transient_high_level_wr) begin
      lo_sel = `ESC_POW_MIN;
      hi_sel = `ESC_POW_MAX;
    end else begin
      lo_sel = `ESC_TIME_MIN;
      hi_sel = `ESC_TIME_MAX;
    end
  end
  esc_clamp #(.W(W)) u_clamp (
    .value  (wr_data),
    .lo     (lo_sel),
    .hi     (hi_sel),
    .result (wr_clamped)
  );

  // Mode register and input enable; mode change forces input off
  logic mode_change;
  assign mode_change = mode_wr & (mode_sel != mode);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode <= esc_pkg::ESC_CUR_LOW;
      input_enabled <= 1'h0;
    end else begin
      if (mode_wr) begin
        mode <= mode_sel;
      end
      if (mode_change | shutdown | input_off_req) begin
        input_enabled <= 1'h0;
      end else if (input_on_req) begin
        input_enabled <= 1'h1;
      end
    end
  end

  // Resistance setpoints; trigger presets are single-use
  logic [W-1:0] res_trig, pow_trig, trans_high;
  logic res_pend, pow_pend;
  logic next_high_range;
  assign next_high_range = (mode_sel == esc_pkg::resistance_high_range_e);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      res_setpoint <= `ESC_RES_LOW_MIN;
      res_trig     <= `ESC_RES_LOW_MIN;
      res_pend     <= 1'h0;
    end else begin
      if (mode_change & res_mode & (next_high_range != high_range) &&
          (mode_sel == esc_pkg::resistance_low_range_e || next_high_range)) begin
        res_setpoint <= next_high_range ? `ESC_RES_HIGH_MIN : `ESC_RES_LOW_MIN;
      end else if (res_wr) begin
        res_setpoint <= wr_clamped;
      end else if (trig_evt & res_pend) begin
        res_setpoint <= res_trig;
      end
      if (res_trig_wr) begin
        res_trig <= wr_clamped;
        res_pend <= 1'h1;
      end else if (trig_evt) begin
        res_pend <= 1'h0;
      end
    end
  end

  // Power setpoints
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pow_setpoint <= `ESC_POW_MIN;
      pow_trig     <= `ESC_POW_MIN;
      pow_pend     <= 1'h0;
    end else begin
      if (pow_wr) begin
        pow_setpoint <= wr_clamped;
      end else if (trig_evt & pow_pend) begin
        pow_setpoint <= pow_trig;
      end
      if (pow_trig_wr) begin
        pow_trig <= wr_clamped;
        pow_pend <= 1'h1;
      end else if (trig_evt) begin
        pow_pend <= 1'h0;
      end
    end
  end

  // Transient high level, clamped to the resistance range in resistance modes, else the power range
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trans_high <= `ESC_POW_MIN;
    end else if (transient_high_level_wr) begin
      trans_high <= wr_clamped;
    end
  end

  // Dwell and edge times in ticks, one entry per parameter
  logic [W-1:0] times [4];
  logic [3:0]   time_wr;
  assign time_wr = {fall_edge_time_wr, rise_edge_time_wr,
                    high_dwell_time_wr, low_dwell_time_wr};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_time
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          times[gi] <= `ESC_TIME_MIN;
        end else if (time_wr[gi]) begin
          times[gi] <= wr_clamped;
        end
      end
    end
  endgenerate

  // 10us tick shared by all transient timing
  logic [15:0] tick_cnt;
  logic        tick;
  assign tick = (tick_cnt == 16'(TICK_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (rst | ~transient_active) begin
      tick_cnt <= 16'h0;
    end else begin
      tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
    end
  end

  // Transient on/off; a shutdown aborts it
  esc_pkg::esc_style_t style;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      transient_active <= 1'h0;
      style <= esc_pkg::ESC_CONT;
    end else begin
      if (~transient_active) begin
        style <= style_sel;
      end
      if (shutdown) begin
        transient_active <= 1'h0;
      end else if (transient_key) begin
        transient_active <= ~transient_active;
      end else if (transient_cmd_on | transient_cmd_off) begin
        transient_active <= transient_cmd_on;
      end
    end
  end

  // Phase sequencer; pulse ignores triggers except at low level
  esc_pkg::esc_phase_t phase;
  logic [W-1:0] ph_cnt;
  logic         ph_done;
  logic         run;
  assign run = transient_active & input_enabled;
  always_comb begin
    case (phase)
      esc_pkg::ESC_RISE: ph_done = ph_cnt + 32'h1 >= times[2];
      esc_pkg::ESC_HIGH: ph_done = ph_cnt + 32'h1 >= times[1];
      esc_pkg::ESC_FALL: ph_done = ph_cnt + 32'h1 >= times[3];
      default:           ph_done = ph_cnt + 32'h1 >= times[0];
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst | ~run) begin
      phase  <= esc_pkg::ESC_LOW;
      ph_cnt <= 32'h0;
    end else begin
      case (phase)
        esc_pkg::ESC_LOW: begin
          if ((style == esc_pkg::ESC_CONT && tick && ph_done) ||
              (style != esc_pkg::ESC_CONT && trig_evt)) begin
            phase  <= esc_pkg::ESC_RISE;
            ph_cnt <= 32'h0;
          end else if (tick && !ph_done) begin
            ph_cnt <= ph_cnt + 32'h1;
          end
        end
        esc_pkg::ESC_HIGH: begin
          // Toggle holds high until the next trigger
          if ((style == esc_pkg::ESC_TOGGLE && trig_evt) ||
              (style != esc_pkg::ESC_TOGGLE && tick && ph_done)) begin
            phase  <= esc_pkg::ESC_FALL;
            ph_cnt <= 32'h0;
          end else if (tick && !ph_done) begin
            ph_cnt <= ph_cnt + 32'h1;
          end
        end
        esc_pkg::ESC_RISE, esc_pkg::ESC_FALL: begin
          if (tick && ph_done) begin
            phase  <= (phase == esc_pkg::ESC_RISE) ? esc_pkg::ESC_HIGH : esc_pkg::ESC_LOW;
            ph_cnt <= 32'h0;
          end else if (tick) begin
            ph_cnt <= ph_cnt + 32'h1;
          end
        end
        default: begin
          phase <= esc_pkg::ESC_LOW;
        end
      endcase
    end
  end

  // Applied setpoint and status outputs
  logic [W-1:0] base_level;
  assign base_level = res_mode ? res_setpoint : pow_setpoint;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      applied_setpoint     <= 32'h0;
      transient_at_high    <= 1'h0;
      transient_in_edge    <= 1'h0;
      voltage_limit_active <= 1'h0;
      trigger_pending      <= 1'h0;
    end else begin
      transient_at_high <= run & (phase == esc_pkg::ESC_HIGH);
      transient_in_edge <= run & ((phase == esc_pkg::ESC_RISE) |
                                  (phase == esc_pkg::ESC_FALL));
      trigger_pending   <= res_pend | pow_pend;
      // Limit mode clamps at the voltage limit when input is above it
      voltage_limit_active <= input_enabled & sync_ovl[1] &
        ((mode == esc_pkg::current_with_voltage_limit_e) |
         (mode == esc_pkg::resistance_with_voltage_limit_e) |
         (mode == esc_pkg::power_with_voltage_limit_e));
      if (!input_enabled) begin
        applied_setpoint <= 32'h0;
      end else if (run && phase == esc_pkg::ESC_HIGH) begin
        applied_setpoint <= trans_high;
      end else if (res_mode | pow_mode) begin
        applied_setpoint <= base_level;
      end else begin
        applied_setpoint <= 32'h0;
      end
    end
  end
endmodule

// ===== esc_ctrl_asserts.sv
// Port-level checks for the setpoint and transient controller
`timescale 1ns/10ps
`include "esc_params.svh"
module esc_ctrl_asserts #(
  parameter int W        = 32,
  parameter int TICK_CYC = `ESC_TICK_CYC
) (
  // Clock, reset and requests
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire esc_pkg::esc_mode_t  mode_sel,
  input wire logic                mode_wr,
  input wire logic                input_on_req,
  input wire logic [W-1:0]        wr_data,
  input wire logic                res_wr,
  input wire logic                res_trig_wr,
  input wire logic                high_dwell_time_wr,
  input wire esc_pkg::esc_style_t style_sel,
  input wire logic                cmd_trigger,
  input wire logic                transient_key,
  input wire logic                transient_cmd_on,
  input wire logic                transient_cmd_off,
  input wire logic                von_shutdown_pin,
  input wire logic                current_prot_pin,
  // Observed outputs
  input wire logic                input_enabled,
  input wire logic                transient_active,
  input wire logic                transient_at_high,
  input wire logic [W-1:0]        res_setpoint,
  input wire logic [W-1:0]        pow_setpoint,
  input wire logic                voltage_limit_active,
  input wire logic                trigger_pending
);
  localparam esc_pkg::esc_mode_t LO = esc_pkg::resistance_low_range_e;
  localparam esc_pkg::esc_mode_t HI = esc_pkg::resistance_high_range_e;
  esc_pkg::esc_mode_t cur_mode;
  logic               known;
  logic               cv_d1;
  logic               cv_d2;
  logic               cv_mode;
  logic [31:0]        hi_cnt;
  logic [31:0]        dwell;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Shadow of the selected mode; unknown until the first write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      known    <= 1'b0;
      cur_mode <= esc_pkg::ESC_CUR_LOW;
    end else if (mode_wr) begin
      known    <= 1'b1;
      cur_mode <= mode_sel;
    end
  end
  // Limit modes, delayed so output latency is tolerated
  assign cv_mode = known && cur_mode >= esc_pkg::current_with_voltage_limit_e;
  always_ff @(posedge sys_clk) begin
    cv_d1 <= cv_mode;
    cv_d2 <= cv_d1;
  end
  // High dwell in ticks, clamped like the design; cycles spent high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dwell <= 32'h0;
    end else if (high_dwell_time_wr) begin
      dwell <= (wr_data == 0) ? `ESC_TIME_MIN :
               (wr_data > `ESC_TIME_MAX) ? `ESC_TIME_MAX : wr_data;
    end
    hi_cnt <= (rst || !transient_at_high) ? 32'h0 : hi_cnt + 32'h1;
  end
  chk_mode_input_off: assert property (
    known && mode_wr && mode_sel != cur_mode && !input_on_req |-> ##[1:2] !input_enabled)
    else $error("input left on across a mode change");
  chk_range_min: assert property (
    known && mode_wr && !res_wr && ((cur_mode == LO && mode_sel == HI) ||
    (cur_mode == HI && mode_sel == LO)) |->
    ##[1:2] res_setpoint == ((cur_mode == HI) ? `ESC_RES_HIGH_MIN : `ESC_RES_LOW_MIN))
    else $error("range switch did not reach new minimum");
  chk_res_low_bound: assert property (
    known && cur_mode == LO && $past(cur_mode, 2) == LO |->
    res_setpoint >= `ESC_RES_LOW_MIN && res_setpoint <= `ESC_RES_LOW_MAX)
    else $error("resistance outside low range");
  chk_pow_bound: assert property (pow_setpoint <= `ESC_POW_MAX)
    else $error("power setpoint above maximum");
  // Pending flag is registered twice: preset latch, then status output
  chk_pend_set: assert property (res_trig_wr |-> ##2 trigger_pending)
    else $error("preset write did not mark a pending trigger");
  chk_trig_idle: assert property (
    cmd_trigger && !trigger_pending && !res_wr && !res_trig_wr && !mode_wr &&
    !$past(mode_wr) && !$past(res_trig_wr) |=> $stable(res_setpoint))
    else $error("trigger without preset changed resistance");
  chk_vlim_mode: assert property (
    voltage_limit_active |-> cv_mode || cv_d1 || cv_d2)
    else $error("voltage limit flagged outside a limit mode");
  chk_shutdown_stop: assert property (
    (von_shutdown_pin || current_prot_pin) [*4] |=> !transient_active)
    else $error("transient kept running through shutdown");
  chk_cmd_enable: assert property (
    (!von_shutdown_pin && !current_prot_pin) [*4] ##0
    (transient_cmd_on && !transient_key && !transient_cmd_off) |-> ##[1:2] transient_active)
    else $error("transient command did not start operation");
  chk_high_dwell: assert property (
    $fell(transient_at_high) && transient_active && dwell != 0 &&
    style_sel != esc_pkg::ESC_TOGGLE |->
    hi_cnt > (dwell - 1) * TICK_CYC && hi_cnt <= dwell * TICK_CYC + 1)
    else $error("high dwell length off its tick count");
  cov_high: cover property ($rose(transient_at_high));
  cov_trig: cover property (trigger_pending ##1 !trigger_pending);
  cov_vlim: cover property ($rose(voltage_limit_active));
endmodule

bind esc_ctrl esc_ctrl_asserts #(.W(W), .TICK_CYC(TICK_CYC)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .mode_sel(mode_sel), .mode_wr(mode_wr),
  .input_on_req(input_on_req), .wr_data(wr_data), .res_wr(res_wr),
  .res_trig_wr(res_trig_wr), .high_dwell_time_wr(high_dwell_time_wr),
  .style_sel(style_sel), .cmd_trigger(cmd_trigger), .transient_key(transient_key),
  .transient_cmd_on(transient_cmd_on), .transient_cmd_off(transient_cmd_off),
  .von_shutdown_pin(von_shutdown_pin), .current_prot_pin(current_prot_pin),
  .input_enabled(input_enabled), .transient_active(transient_active),
  .transient_at_high(transient_at_high), .res_setpoint(res_setpoint),
  .pow_setpoint(pow_setpoint), .voltage_limit_active(voltage_limit_active),
  .trigger_pending(trigger_pending));

// ===== esc_host_model.sv
// Host-side trigger source on the external trigger terminal
`timescale 1ns/10ps
module esc_host_model (
  // Clock and request from the sequence
  input  wire logic sys_clk,
  input  wire logic fire,
  // External trigger terminal, idles low
  output logic      ext_trigger_pin
);
  logic [2:0] hold = 3'h0;
  // Held several cycles so the synchroniser cannot miss it; presets go over
  // the command strobes only
  always @(posedge sys_clk) begin
    if (fire) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign ext_trigger_pin = (hold != 3'h0);
endmodule

// ===== esc_ctrl_tb.sv
// Self-checking bench for the setpoint and transient controller
`timescale 1ns/10ps
`include "esc_params.svh"
module esc_ctrl_tb;
  localparam int TCK = 4;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  esc_pkg::esc_mode_t  mode_sel = esc_pkg::ESC_CUR_LOW;
  esc_pkg::esc_style_t style_sel = esc_pkg::ESC_CONT;
  logic [31:0]         wr_data = 32'h0;
  logic [8:0]          ws = 9'h0;
  logic [6:0]          pv = 7'h0;
  logic                fire = 1'b0;
  logic                von = 1'b0;
  logic                cprot = 1'b0;
  logic                ovl = 1'b0;
  logic                ext_trig;
  logic                in_en, t_act, t_high, t_edge, vlim, pend;
  logic [31:0]         res_sp, pow_sp, app_sp;
  int                  fail_count = 0;
  int                  num_checks = 0;
  // Clock, 25 ns period
  always #12.5 sys_clk = ~sys_clk;
  esc_host_model host (.sys_clk(sys_clk), .fire(fire), .ext_trigger_pin(ext_trig));
  esc_ctrl #(.TICK_CYC(TCK)) dut (
    .sys_clk(sys_clk), .rst(rst), .mode_sel(mode_sel), .mode_wr(pv[0]),
    .input_on_req(pv[1]), .input_off_req(pv[2]), .wr_data(wr_data), .res_wr(ws[0]),
    .res_trig_wr(ws[1]), .pow_wr(ws[2]), .pow_trig_wr(ws[3]),
    .transient_high_level_wr(ws[4]), .high_dwell_time_wr(ws[5]),
    .low_dwell_time_wr(ws[6]), .rise_edge_time_wr(ws[7]), .fall_edge_time_wr(ws[8]),
    .style_sel(style_sel), .transient_key(pv[3]), .transient_cmd_on(pv[4]),
    .transient_cmd_off(pv[5]), .ext_trigger_pin(ext_trig), .cmd_trigger(pv[6]),
    .von_shutdown_pin(von), .current_prot_pin(cprot), .over_voltage_limit_pin(ovl),
    .input_enabled(in_en), .transient_active(t_act), .transient_at_high(t_high),
    .transient_in_edge(t_edge), .res_setpoint(res_sp), .pow_setpoint(pow_sp),
    .applied_setpoint(app_sp), .voltage_limit_active(vlim), .trigger_pending(pend));
  // Compare and count
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Let edges pass, then sample settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Value strobe: 0 res, 1 res preset, 2 pow, 3 pow preset, 4 high level, 5-8 times
  task automatic wr(input int k, input logic [31:0] d);
    @(posedge sys_clk);
    wr_data <= d;
    ws <= 9'h1 << k;
    @(posedge sys_clk);
    ws <= 9'h0;
    settle(3);
  endtask
  // Control pulse: 0 mode, 1 on, 2 off, 3 key, 4 start, 5 stop, 6 trigger
  task automatic pulse(input int k);
    @(posedge sys_clk);
    pv <= 7'h1 << k;
    @(posedge sys_clk);
    pv <= 7'h0;
    settle(3);
  endtask
  task automatic set_mode(input esc_pkg::esc_mode_t m);
    @(posedge sys_clk);
    mode_sel <= m;
    pulse(0);
  endtask
  // Bounded wait for a settled transient level
  task automatic wait_phase(input logic hi);
    for (int i = 0; i < 400; i++) begin
      settle(1);
      if (t_high === hi && t_edge === 1'b0) begin
        return;
      end
    end
    check("transient phase wait", 32'h0, 32'h1);
    stop_test();
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    check("res reset", res_sp, `ESC_RES_LOW_MIN);
    set_mode(esc_pkg::resistance_low_range_e);
    wr(0, 32'h0);
    check("res low clamp", res_sp, `ESC_RES_LOW_MIN);
    wr(0, 32'hffff_ffff);
    check("res high clamp", res_sp, `ESC_RES_LOW_MAX);
    pulse(1);
    wr(1, 32'h0000_07d0);
    check("pending", {31'h0, pend}, 32'h1);
    pulse(6);
    check("res triggered", res_sp, 32'h0000_07d0);
    check("applied res", app_sp, 32'h0000_07d0);
    wr(0, 32'h0000_0064);
    pulse(6);
    check("res spent trigger", res_sp, 32'h0000_0064);
    set_mode(esc_pkg::resistance_high_range_e);
    check("input off", {31'h0, in_en}, 32'h0);
    check("res range min", res_sp, `ESC_RES_HIGH_MIN);
    wr(0, 32'h0000_03e8);
    set_mode(esc_pkg::resistance_low_range_e);
    check("res low range min", res_sp, `ESC_RES_LOW_MIN);
    set_mode(esc_pkg::constant_power_mode_e);
    wr(2, 32'hffff_ffff);
    check("pow clamp", pow_sp, `ESC_POW_MAX);
    wr(2, 32'h0000_03e8);
    pulse(1);
    wr(1, 32'h0000_0050);
    wr(3, 32'h0000_07d0);
    @(posedge sys_clk);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    settle(8);
    check("pow triggered", pow_sp, 32'h0000_07d0);
    check("applied pow", app_sp, 32'h0000_07d0);
    check("res preset", res_sp, 32'h0000_0050);
    for (int i = 7; i < 10; i++) begin
      set_mode(esc_pkg::esc_mode_t'(i));
      pulse(1);
      @(posedge sys_clk);
      ovl <= 1'b1;
      settle(5);
      check("vlimit on", {31'h0, vlim}, 32'h1);
      @(posedge sys_clk);
      ovl <= 1'b0;
      settle(5);
      check("vlimit off", {31'h0, vlim}, 32'h0);
    end
    set_mode(esc_pkg::resistance_low_range_e);
    wr(0, 32'h0000_0064);
    wr(4, 32'hffff_ffff);
    wr(5, 32'h0);
    for (int k = 6; k < 9; k++) begin
      wr(k, 32'h2);
    end
    pulse(1);
    // Every style: start, fire where needed, reach the clamped high level
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      style_sel <= esc_pkg::esc_style_t'(s);
      pulse(4);
      check("transient on", {31'h0, t_act}, 32'h1);
      if (s != 0) begin
        pulse(6);
      end
      wait_phase(1'b1);
      settle(1);
      check("high level", app_sp, `ESC_RES_LOW_MAX);
      // Toggle needs a second trigger to fall; the others fall on their own
      if (s == 2) begin
        pulse(6);
      end
      wait_phase(1'b0);
      settle(1);
      check("low level", app_sp, 32'h0000_0064);
      pulse(5);
    end
    @(posedge sys_clk);
    style_sel <= esc_pkg::ESC_CONT;
    pulse(4);
    @(posedge sys_clk);
    von <= 1'b1;
    settle(6);
    check("von stop", {31'h0, t_act}, 32'h0);
    @(posedge sys_clk);
    von <= 1'b0;
    settle(4);
    pulse(1);
    pulse(3);
    check("key start", {31'h0, t_act}, 32'h1);
    @(posedge sys_clk);
    cprot <= 1'b1;
    settle(6);
    check("prot stop", {31'h0, t_act}, 32'h0);
    stop_test();
  end
endmodule
